// ### hdl/time_base_generator.sv
// time base generator: divided clock taps plus watchdog / interval timer
// assumes one 20 MHz core clock, synchronous reset, plain register port
`timescale 1ns/100ps
`include "timebase_consts.svh"
module time_base_generator
#(
  parameter int WD_W  = 12,
  parameter int TBC_W = 8
)
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire timebase_pkg::reg_req_t  regReq,
  output logic [31:0]                  regRdData,
  output logic [TBC_W-1:0]             dividedClockTaps,
  output logic                         watchdogResetRequest,
  output logic                         intervalInterruptRequest
);

  // ---- state ----
  timebase_pkg::ctrl_t      ctrlReg;     // timebase control register
  timebase_pkg::ctrl_t      ctrlNext;    // value a keyed write loads
  timebase_pkg::svc_state_t svcReg;      // service key sequence position
  logic                     unlockReg;   // last write was the unlock key
  logic                     runReg;      // watchdog counter started
  logic [31:0]              rdDataReg;   // read answer, one cycle

  // ---- decode ----
  logic             svcWr;      // write to the service register
  logic             ctrlWr;     // write to the control register
  logic             ctrlRd;     // read of the control register
  logic             ctrlUpd;    // keyed control update this cycle
  logic [7:0]       wByte;      // written byte
  logic             keyStart;   // written byte is the start key
  logic             keyAlt;     // written byte is the alternate key
  logic             svcClear;   // service write clears the counter
  logic             wdClear;    // any cause of a counter clear
  logic             countEn;    // watchdog count tick
  logic             modeAllows; // mode lets the counter advance
  logic [TBC_W-1:0] tapTick;    // per-tap period ticks
  logic [WD_W-1:0]  wdCount;    // watchdog count, never readable
  logic             wdOverflow; // counter wrapped this cycle

  // the mode bits, named for readability
  logic interval_mode_select;   // interval timer operation selected
  logic interval_enable;  // interval counting enabled

  // pick the tick of the selected watchdog count clock
  function automatic logic selTick(input logic [TBC_W-1:0] ticks,
                                   input logic [1:0]       sel);
    logic picked;
    picked = ticks[`TAP_SEL_BASE + int'(sel)];
    return picked;
  endfunction

  // address match on a strobe
  function automatic logic hit(input logic strobe,
                               input logic [31:0] addr,
                               input logic [31:0] offset);
    return strobe && (addr == offset);
  endfunction

  assign wByte    = regReq.wdata[7:0];
  assign svcWr    = hit(regReq.wr, regReq.addr, `SVC_OFFSET);
  assign ctrlWr   = hit(regReq.wr, regReq.addr, `CTRL_OFFSET);
  assign ctrlRd   = hit(regReq.rd, regReq.addr, `CTRL_OFFSET);
  assign keyStart = (wByte == `KEY_START);
  assign keyAlt   = (wByte == `KEY_ALT);
  assign interval_mode_select      = ctrlReg.intervalModeSelect;
  assign interval_enable     = ctrlReg.intervalEnable;

  // keyed update only right after the unlock write
  assign ctrlUpd  = ctrlWr && unlockReg;
  // unused bits are never stored, so they read back as zero
  assign ctrlNext = timebase_pkg::ctrl_t'(wByte & `CTRL_WMASK);

  // ---- time base counter and taps ----
  time_base_counter
  #(
    .TBC_W (TBC_W)
  )
  uTbc
  (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .dividedClockTaps (dividedClockTaps),
    .tapTick          (tapTick)
  );

  // ---- unlock tracking ----
  // any write between the key and the value breaks the pair, and a
  // write that consumes the key never arms again by itself
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      unlockReg <= 1'b0;
    else if (regReq.wr)
      unlockReg <= ctrlWr && !unlockReg && (wByte == `KEY_UNLOCK);
  end

  // ---- control register ----
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ctrlReg <= timebase_pkg::ctrl_t'(`CTRL_RESET);
    else if (ctrlUpd)
      ctrlReg <= ctrlNext;
  end

  // ---- service write decode ----
  // watchdog mode clears on the start write and at the end of an alternating pair; other
  // values and out of order keys fall through with no effect
  always_comb
  begin
    svcClear = 1'b0;
    if (svcWr)
    begin
      if (!interval_mode_select)
      begin
        // start write, or the start key that closes a pair
        svcClear = keyStart && (svcReg != timebase_pkg::SVC_WANT_ALT);
      end
      else if (interval_enable)
      begin
        svcClear = keyStart;
      end
    end
  end

  // a keyed control update also restarts the count
  assign wdClear = svcClear || ctrlUpd;

  // ---- run flag and key sequence ----
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      runReg <= 1'b0;
      svcReg <= timebase_pkg::SVC_STOPPED;
    end
    else if (ctrlUpd)
    begin
      if (!ctrlNext.intervalModeSelect)
      begin
        // leaving interval mode restarts watchdog operation at zero
        if (interval_mode_select)
        begin
          runReg <= 1'b1;
          svcReg <= timebase_pkg::SVC_WANT_ALT;
        end
      end
      else if (!ctrlNext.intervalEnable || !(interval_mode_select && interval_enable))
      begin
        // interval stopped, or newly enabled and awaiting the start key
        runReg <= 1'b0;
        svcReg <= timebase_pkg::SVC_STOPPED;
      end
    end
    else if (svcWr)
    begin
      if (interval_mode_select)
      begin
        if (interval_enable && keyStart)
          runReg <= 1'b1;
      end
      else
      begin
        unique case (svcReg)
          timebase_pkg::SVC_STOPPED:
          begin
            if (keyStart)
            begin
              runReg <= 1'b1;
              svcReg <= timebase_pkg::SVC_WANT_ALT;
            end
          end
          timebase_pkg::SVC_WANT_ALT:
          begin
            if (keyAlt)
              svcReg <= timebase_pkg::SVC_WANT_START;
          end
          timebase_pkg::SVC_WANT_START:
          begin
            if (keyStart)
              svcReg <= timebase_pkg::SVC_WANT_ALT;
            else if (keyAlt)
              svcReg <= timebase_pkg::SVC_WANT_START;
          end
        endcase
      end
    end
  end

  // ---- count enable ----
  // no halt input on purpose: the count goes on while the core sleeps
  assign modeAllows = !interval_mode_select || interval_enable;
  // m-cycle tick times 4096 counts gives the overflow interval
  assign countEn = runReg && modeAllows &&
                   selTick(tapTick, ctrlReg.watchdogClockSelect);

  watchdog_counter
  #(
    .WD_W (WD_W)
  )
  uWdc
  (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .clear    (wdClear),
    .countEn  (countEn),
    .count    (wdCount),
    .overflow (wdOverflow)
  );

  // ---- overflow outputs ----
  // one-cycle pulses; the reset controller outside stretches the reset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      watchdogResetRequest     <= 1'b0;
      intervalInterruptRequest <= 1'b0;
    end
    else
    begin
      watchdogResetRequest     <= wdOverflow && !interval_mode_select;
      intervalInterruptRequest <= wdOverflow && interval_mode_select;
    end
  end

  // ---- read port ----
  // only the control register answers; the service register and the
  // count read as zero, as does every unmapped address
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdDataReg <= '0;
    else if (ctrlRd)
      rdDataReg <= {24'h00_0000, ctrlReg};
    else
      rdDataReg <= '0;
  end

  assign regRdData = rdDataReg;

  // ---- checks ----
  // all checks sleep during reset except the tap check, which is about reset;
  // the count is internal, so only these assertions can see it
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  taps_reset_low_a: assert property (disable iff (1'b0) rst |=> dividedClockTaps == '0)
    else $error("taps not low after reset");

  starts_disabled_a: assert property ($past(rst) |-> !runReg && wdCount == '0)
    else $error("watchdog running after reset");

  ctrl_reset_a: assert property ($past(rst) |-> ctrlReg == `CTRL_RESET)
    else $error("control not zero after reset");

  start_key_a: assert property (svcWr && keyStart && !interval_mode_select && !runReg |=> runReg && wdCount == '0)
    else $error("start key did not start watchdog");

  pair_clear_a: assert property (svcWr && !interval_mode_select && keyStart &&
    svcReg == timebase_pkg::SVC_WANT_START |=> wdCount == '0)
    else $error("alternating pair did not clear");

  bad_service_a: assert property (svcWr && !interval_mode_select && runReg && !keyStart |=> wdCount == $past(wdCount) || wdCount == WD_W'($past(wdCount) + 1'b1))
    else $error("wrong service write changed count");

  interval_start_a: assert property (svcWr && keyStart && interval_mode_select && interval_enable && !ctrlUpd |=> runReg && wdCount == '0)
    else $error("interval start key ignored");

  wd_reset_req_a: assert property (wdOverflow && !interval_mode_select |=> watchdogResetRequest && !intervalInterruptRequest)
    else $error("overflow did not request reset");

  irq_not_reset_a: assert property (wdOverflow && interval_mode_select |=> intervalInterruptRequest && !watchdogResetRequest)
    else $error("interval overflow misrouted");

  locked_write_a: assert property (ctrlWr && !unlockReg |=> ctrlReg == $past(ctrlReg))
    else $error("control changed without unlock");

  update_clears_a: assert property (ctrlUpd |=> wdCount == '0)
    else $error("control update kept count");

  interval_stop_a: assert property (interval_mode_select && !interval_enable && !ctrlUpd |=> wdCount == $past(wdCount))
    else $error("stopped interval timer counted");

  mode_back_a: assert property (ctrlUpd && interval_mode_select && !ctrlNext.intervalModeSelect |=> runReg && wdCount == '0 && !interval_mode_select)
    else $error("watchdog did not restart");

  service_read_a: assert property (regReq.rd && !ctrlRd |=> regRdData == '0)
    else $error("non-control read not zero");

  spare_bits_a: assert property (ctrlRd |=> regRdData[7:5] == 3'h0 && regRdData[2] == 1'b0)
    else $error("unused control bit read one");

  tick_spacing_a: assert property (tapTick[7] |=> !tapTick[7] [*8])
    else $error("divide-by-256 tick too frequent");

  count_step_a: assert property (countEn && !wdClear |=> wdCount == WD_W'($past(wdCount) + 1'b1))
    else $error("count did not step on tick");

  tap_step_a: assert property (!$past(rst) |->
    dividedClockTaps == TBC_W'($past(dividedClockTaps) + 1'b1))
    else $error("taps did not step by one");

  stop_hold_a: assert property (!runReg |=> wdCount == $past(wdCount) || wdCount == '0)
    else $error("stopped watchdog counted");

  reset_pulse_a: assert property (watchdogResetRequest |=> !watchdogResetRequest)
    else $error("reset request longer than a cycle");

  irq_pulse_a: assert property (intervalInterruptRequest |=> !intervalInterruptRequest)
    else $error("interrupt request longer than a cycle");

  clear_wins_a: assert property (wdClear |-> !wdOverflow)
    else $error("overflow despite a clear");

endmodule

// ### hdl/timebase_consts.svh
// constants of the time base generator: offsets, keys, reset values
// assumes it is included by bare name from the top design file and the test bench
`ifndef TIMEBASE_CONSTS_SVH
`define TIMEBASE_CONSTS_SVH

// byte addresses on the register port
`define SVC_OFFSET   32'h0060_0200
`define CTRL_OFFSET  32'h0060_0204

// service keys and the control unlock key
`define KEY_START    8'h3C
`define KEY_ALT      8'hC3
`define KEY_UNLOCK   8'h5A

// control register reset value and writable bits (bits 7..5, 2 unused)
`define CTRL_RESET   8'h00
`define CTRL_WMASK   8'h1B

// tap index of the divide-by-32 tick, first of the watchdog choices
`define TAP_SEL_BASE 4

`endif

// ### hdl/timebase_pkg.sv
// types shared by the time base generator files
// assumes nothing beyond a SystemVerilog compiler
package timebase_pkg;

  // one access on the register port
  typedef struct packed {
    logic [31:0] addr;   // byte address
    logic [31:0] wdata;  // write data, low byte used
    logic        wr;     // write strobe, one cycle
    logic        rd;     // read strobe, one cycle
  } reg_req_t;

  // timebase control register layout
  typedef struct packed {
    logic [2:0] spareHigh;            // unused, read zero
    logic       intervalEnable;       // interval counting allowed
    logic       intervalModeSelect;   // 0 watchdog, 1 interval timer
    logic       spareLow;             // unused, read zero
    logic [1:0] watchdogClockSelect;  // count tick choice
  } ctrl_t;

  // position in the watchdog service key sequence
  typedef enum logic [1:0] {
    SVC_STOPPED,
    SVC_WANT_ALT,
    SVC_WANT_START
  } svc_state_t;

endpackage

// ### hdl/time_base_counter.sv
// free running time base counter with divided clock taps and ticks
// assumes one core clock and a synchronous active high reset
`timescale 1ns/100ps
module time_base_counter
#(
  parameter int TBC_W = 8
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  output logic [TBC_W-1:0] dividedClockTaps,
  output logic [TBC_W-1:0] tapTick
);

  logic [TBC_W-1:0] countReg;  // counts every core clock

  // the watchdog picks taps up to divide-by-256, so fewer bits cannot serve
  if (TBC_W < 8)
  begin : gBadWidth
    $error("time_base_counter needs at least eight bits");
  end

  // counter restarts from zero on reset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      countReg <= '0;
    else
      countReg <= countReg + 1'b1;
  end

  // taps copy the counter on the falling edge, so they move there
  // bit k divides the core clock by 2 to the power k+1
  always_ff @(negedge clk_sys)
  begin
    if (rst)
      dividedClockTaps <= '0;
    else
      dividedClockTaps <= countReg;
  end

  // one-cycle tick when a tap completes its period; used as an enable
  // instead of the tap itself so nothing else runs on a derived clock
  for (genvar k = 0; k < TBC_W; k++)
  begin : gTick
    assign tapTick[k] = &countReg[k:0];
  end

endmodule

// ### hdl/watchdog_counter.sv
// watchdog count register with clear, enable and overflow detect
// assumes clear and enable come from the same core clock domain
`timescale 1ns/100ps
module watchdog_counter
#(
  parameter int WD_W = 12
)
(
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic            clear,
  input  wire logic            countEn,
  output logic [WD_W-1:0] count,
  output logic            overflow
);

  // a one bit counter would overflow on every second tick
  if (WD_W < 2)
  begin : gBadWidth
    $error("watchdog_counter needs at least two bits");
  end

  // clear wins over counting so a service write never loses to a tick
  always_ff @(posedge clk_sys)
  begin
    if (rst || clear)
      count <= '0;
    else if (countEn)
      count <= count + 1'b1;
  end

  // wrap from all ones is the overflow event
  assign overflow = countEn && !clear && (&count);

endmodule

// ### dv/time_base_generator_test.sv
// self-checking bench for the time base generator: taps, register port, watchdog modes
// assumes the hdl/ design files; a narrow watchdog width keeps every overflow short
`timescale 1ns/100ps
`include "timebase_consts.svh"
module time_base_generator_test;
  localparam int          WD_W = 4;             // 16 ticks to overflow, not 4096
  localparam int          LAST = 16;            // ticks from zero to overflow at WD_W
  localparam logic [31:0] CT   = `CTRL_OFFSET;  // control register address
  localparam logic [31:0] SV   = `SVC_OFFSET;   // service register address

  // one register access row and the read data it should give
  typedef struct {
    bit          isRd;  // read row when set
    logic [31:0] addr;  // byte address
    logic [7:0]  data;  // write data
    logic [31:0] exp;   // expected read data
  } row_t;

  logic                   clk_sys;                   // core clock
  logic                   rst;                       // synchronous reset
  timebase_pkg::reg_req_t regReq;                    // register request
  logic [31:0]            regRdData;                 // read data
  logic [7:0]             dividedClockTaps;          // divided clock taps
  logic                   watchdogResetRequest;      // reset request pulse
  logic                   intervalInterruptRequest;  // interrupt request pulse
  int                     errorCnt;                  // mismatches
  int                     totalChecks;               // comparisons
  row_t                   rows [15];                 // register access table
  logic [31:0]            rdVal;                     // last read data
  logic [7:0]             tapB;                      // taps after last fall

  time_base_generator #(.WD_W(WD_W), .TBC_W(8)) dut_u (
    .clk_sys                  (clk_sys),
    .rst                      (rst),
    .regReq                   (regReq),
    .regRdData                (regRdData),
    .dividedClockTaps         (dividedClockTaps),
    .watchdogResetRequest     (watchdogResetRequest),
    .intervalInterruptRequest (intervalInterruptRequest)
  );

  // 50 ns core clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // single exit of the run
  task automatic conclude();
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one bus cycle; strobes are left up so writes can go back to back
  task automatic drive(input bit wr, input bit rd, input logic [31:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    regReq <= timebase_pkg::reg_req_t'{addr: addr, wdata: {24'h000000, data}, wr: wr, rd: rd};
  endtask

  // read: data stands only in the cycle after the strobe, sampled mid-cycle
  task automatic readReg(input logic [31:0] addr, output logic [31:0] data);
    drive(1'b0, 1'b1, addr, 8'h00);
    drive(1'b0, 1'b0, 32'h00000000, 8'h00);
    @(negedge clk_sys);
    data = regRdData;
  endtask

  // keyed control update, then release the bus
  task automatic ctrlWrite(input logic [7:0] v);
    drive(1'b1, 1'b0, CT, `KEY_UNLOCK);
    drive(1'b1, 1'b0, CT, v);
    drive(1'b0, 1'b0, 32'h00000000, 8'h00);
  endtask

  // service write, then release the bus
  task automatic svc(input logic [7:0] v);
    drive(1'b1, 1'b0, SV, v);
    drive(1'b0, 1'b0, 32'h00000000, 8'h00);
  endtask

  // n cycles with neither request seen
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      @(negedge clk_sys);
      seen = seen | watchdogResetRequest | intervalInterruptRequest;
    end
    check("quietRequests", {31'h0, seen}, 32'h0);
  endtask

  // cycles to the chosen request must match 16 ticks of divide ratio m,
  // less the ago cycles that had already passed since the last clear
  task automatic measure(input bit irq, input int m, input int ago);
    int   n;
    logic other;
    n = 0;
    other = 1'b0;
    do
    begin
      @(negedge clk_sys);
      n++;
      other = other | (irq ? watchdogResetRequest : intervalInterruptRequest);
    end
    while ((irq ? intervalInterruptRequest : watchdogResetRequest) !== 1'b1 && n < LAST*m + 40);
    if (n >= LAST*m + 40)
    begin
      check("overflowRequest", 32'h0, 32'h1);
      conclude();
    end
    else
    begin
      check("overflowWindow", 32'(n >= (LAST-1)*m - ago - 4 && n <= LAST*m - ago + 4), 32'h1);
      check("otherRequest", {31'h0, other}, 32'h0);
    end
  endtask

  // hang guard: well past the longest legal run
  initial
  begin
    #(50*100000);
    check("runTime", 32'h0, 32'h1);
    conclude();
  end

  // main sequence
  initial
  begin
    errorCnt = 0;
    totalChecks = 0;
    rst = 1'b1;
    regReq = '0;
    rows = '{
      '{1, CT, 8'h00, 32'h00}, '{0, CT, 8'h1B, 32'h00}, '{1, CT, 8'h00, 32'h00},
      '{0, CT, 8'h5A, 32'h00}, '{0, CT, 8'hFF, 32'h00}, '{1, CT, 8'h00, 32'h1B},
      '{1, SV, 8'h00, 32'h00}, '{1, 32'h00600208, 8'h00, 32'h00},
      '{0, CT, 8'h5A, 32'h00}, '{1, CT, 8'h00, 32'h1B}, '{0, CT, 8'h04, 32'h00},
      '{1, CT, 8'h00, 32'h00}, '{0, CT, 8'h5A, 32'h00}, '{0, CT, 8'h5A, 32'h00},
      '{1, CT, 8'h00, 32'h1A}};
    repeat (2) @(posedge clk_sys);
    check("tapsInReset", {24'h0, dividedClockTaps}, 32'h0);
    rst <= 1'b0;
    quiet(600);
    // taps hold at the rising edge and step by one at each falling edge
    @(negedge clk_sys);
    #1 tapB = dividedClockTaps;
    repeat (260)
    begin
      @(posedge clk_sys);
      #1 check("tapsAtRise", {24'h0, dividedClockTaps}, {24'h0, tapB});
      @(negedge clk_sys);
      #1 check("tapsAtFall", {24'h0, dividedClockTaps}, {24'h0, tapB + 8'h01});
      tapB = dividedClockTaps;
    end
    // ordinary register accesses from the table
    foreach (rows[i])
    begin
      if (rows[i].isRd)
      begin
        readReg(rows[i].addr, rdVal);
        check("regRead", rdVal, rows[i].exp);
      end
      else
        drive(1'b1, 1'b0, rows[i].addr, rows[i].data);
    end
    // every clock select; the update itself clears the count
    for (int s = 0; s < 4; s++)
    begin
      ctrlWrite(8'(s));
      measure(1'b0, 32 << s, 0);
    end
    // alternating keys keep it alive; lone or wrong keys do not
    ctrlWrite(8'h00);
    repeat (4)
    begin
      quiet(300);
      svc(`KEY_ALT);
      svc(`KEY_START);
    end
    quiet(300);
    svc(`KEY_START);
    svc(8'h55);
    measure(1'b0, 32, 300);
    // interval mode: armed, started, cleared, then parked and back to watchdog
    ctrlWrite(8'h18);
    quiet(600);
    svc(`KEY_START);
    measure(1'b1, 32, 0);
    repeat (3)
    begin
      quiet(300);
      svc(`KEY_START);
    end
    ctrlWrite(8'h08);
    quiet(600);
    ctrlWrite(8'h00);
    measure(1'b0, 32, 0);
    // reset in mid run, then a plain start key
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check("tapsAfterReset", {24'h0, dividedClockTaps}, 32'h0);
    rst <= 1'b0;
    readReg(CT, rdVal);
    check("ctrlAfterReset", rdVal, 32'h0);
    quiet(600);
    svc(`KEY_START);
    measure(1'b0, 32, 0);
    conclude();
  end
endmodule
